/* File: rtl/lbs_top.sv */
// lfps burst generator and classifier for one link port
// assumes an analog lfps oscillator gated by txLfps and a squelch
// detector giving rxLfps, both synchronous to ref_clk
//
// Contract
// - each sent lfps cycle has a 20-100 ns period, 20-80 ns at enhanced rate.
// - a burst is sent without gaps for its whole length.
// - repeating sequences send one burst per interval, idle in between.
// - message type is set by burst length on both send and receive.
// - polling bursts last 0.6-1.4 us and repeat every 6-14 us.
// - ping bursts last 40-200 ns, two or more cycles, every 160-240 ms.
// - at enhanced rate or two lanes the ping maximum drops to 160 ns.
// - a ping is recognised from its own burst, not from its interval.
// - warm reset is one continuous burst of 80-120 ms.
// - warm reset, exits and wakeup are single bursts without repeat.
// - a u1 exit burst lasts at least 900 ns and at most 2 ms.
// - a received u1 exit is recognised after 300 ns of lfps.
// - u2, loopback exit and u3 wakeup bursts last 80 us to 2 or 10 ms.
// - with two lanes only the configuration lane carries lfps.
// - during an exit handshake lfps continues until it is declared done.
`include "lbs_cfg.svh"
module lbs_top #(
   parameter int LANES = 2,                          // lane count
   parameter int CNT_W = 21,                         // burst counter width
   parameter int PING_REP_CYC = `LBS_PING_REP_CYC,   // ping interval
   parameter int WARM_CYC = `LBS_WARM_CYC,           // warm reset length
   parameter int MAX2MS_CYC = `LBS_MAX2MS_CYC,       // 2 ms exit limit
   parameter int U3_MAX_CYC = `LBS_U3_MAX_CYC        // wakeup limit
) (
   input wire logic ref_clk,                 // 10 MHz local clock
   input wire logic rst_n,                   // async reset, active low
   input wire logic reqValid,                // start request
   input wire lbs_pkg::lbs_kind_t reqKind,   // message to send
   output logic reqReady,                    // request taken when high
   input wire logic txStop,                  // handshake declared / stop
   input wire logic enhRate,                 // gen2 or two-lane design
   input wire logic rxLfps,                  // squelch detector level
   output logic [LANES-1:0] txLfps,          // lfps enable per lane
   output logic [LANES-1:0] txElecIdle,      // electrical idle per lane
   output logic periodSel,                   // 1: period within 80 ns
   output logic txDone,                      // sequence ended normally
   output logic txTimeout,                   // exit burst hit its limit
   output logic rxPing,                      // ping received
   output logic rxPoll,                      // polling burst received
   output logic rxU1Exit,                    // 300 ns of lfps received
   output logic rxLongBurst                  // 80 us of lfps received
);
   localparam logic [CNT_W-1:0] POLL_B = CNT_W'(`LBS_POLL_BURST_CYC);
   localparam logic [CNT_W-1:0] POLL_R = CNT_W'(`LBS_POLL_REP_CYC);
   localparam logic [CNT_W-1:0] PING_B = CNT_W'(`LBS_PING_CYC);
   localparam logic [CNT_W-1:0] PING_BE = CNT_W'(`LBS_PING_ENH_CYC);
   localparam logic [CNT_W-1:0] PING_R = CNT_W'(PING_REP_CYC);
   localparam logic [CNT_W-1:0] WARM = CNT_W'(WARM_CYC);
   localparam logic [CNT_W-1:0] U1_MIN = CNT_W'(`LBS_U1_MIN_CYC);
   localparam logic [CNT_W-1:0] EXIT_MIN = CNT_W'(`LBS_EXIT_MIN_CYC);
   localparam logic [CNT_W-1:0] MAX2MS = CNT_W'(MAX2MS_CYC);
   localparam logic [CNT_W-1:0] U3_MAX = CNT_W'(U3_MAX_CYC);

   lbs_pkg::lbs_tx_state_t stateReg, stateNext;
   lbs_pkg::lbs_kind_t kindReg, kindNext;
   logic [CNT_W-1:0] cntReg, cntNext;
   logic enhReg, enhNext;
   logic stopReg, stopNext;
   logic doneNext, toutNext, periodNext;
   logic burstOn, isRep, isExit;
   logic [CNT_W-1:0] burstLen, repLen, exitMin, exitMax;

   lbs_evt_if evt ();

   assign burstOn = (stateReg == lbs_pkg::TX_BURST);
   assign reqReady = (stateReg == lbs_pkg::TX_IDLE);

   // lengths selected by the message kind
   always_comb begin
      isRep = (kindReg == lbs_pkg::K_POLL) ||
              (kindReg == lbs_pkg::K_PING);
      isExit = (kindReg == lbs_pkg::K_U1) || (kindReg == lbs_pkg::K_U2) ||
               (kindReg == lbs_pkg::K_LPBK) || (kindReg == lbs_pkg::K_U3);
      burstLen = POLL_B;
      repLen = POLL_R;
      if (kindReg == lbs_pkg::K_PING) begin
         burstLen = enhReg ? PING_BE : PING_B;
         repLen = PING_R;
      end
      exitMin = (kindReg == lbs_pkg::K_U1) ? U1_MIN : EXIT_MIN;
      exitMax = (kindReg == lbs_pkg::K_U3) ? U3_MAX : MAX2MS;
   end

   // sequencer; cntReg counts from the start of each burst
   always_comb begin
      stateNext = stateReg;
      kindNext = kindReg;
      enhNext = enhReg;
      cntNext = cntReg;
      stopNext = stopReg;
      doneNext = 1'b0;
      toutNext = 1'b0;
      periodNext = enhRate;
      case (stateReg)
         lbs_pkg::TX_IDLE: begin
            if (reqValid) begin
               kindNext = reqKind;
               enhNext = enhRate;
               cntNext = '0;
               stopNext = 1'b0;
               stateNext = lbs_pkg::TX_BURST;
            end
         end
         lbs_pkg::TX_BURST: begin
            cntNext = cntReg + 1'b1;
            // a stop is remembered until the burst may end
            stopNext = stopReg | txStop;
            if (isRep) begin
               if (cntReg == burstLen - 1'b1) begin
                  stateNext = stopNext ? lbs_pkg::TX_IDLE : lbs_pkg::TX_GAP;
                  doneNext = stopNext;
               end
            end else if (kindReg == lbs_pkg::K_WARM) begin
               if (cntReg == WARM - 1'b1) begin
                  stateNext = lbs_pkg::TX_IDLE;
                  doneNext = 1'b1;
               end
            end else if (stopNext && cntReg >= exitMin - 1'b1) begin
               stateNext = lbs_pkg::TX_IDLE;
               doneNext = 1'b1;
            end else if (cntReg == exitMax - 1'b1) begin
               stateNext = lbs_pkg::TX_IDLE;
               toutNext = 1'b1;
            end
         end
         lbs_pkg::TX_GAP: begin
            cntNext = cntReg + 1'b1;
            if (txStop) begin
               stateNext = lbs_pkg::TX_IDLE;
               doneNext = 1'b1;
            end else if (cntReg == repLen - 1'b1) begin
               cntNext = '0;
               stateNext = lbs_pkg::TX_BURST;
            end
         end
         default: begin
            stateNext = lbs_pkg::TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= lbs_pkg::TX_IDLE;
         kindReg <= lbs_pkg::K_POLL;
         enhReg <= 1'b0;
         cntReg <= '0;
         stopReg <= 1'b0;
         txDone <= 1'b0;
         txTimeout <= 1'b0;
         periodSel <= 1'b0;
      end else begin
         stateReg <= stateNext;
         kindReg <= kindNext;
         enhReg <= enhNext;
         cntReg <= cntNext;
         stopReg <= stopNext;
         txDone <= doneNext;
         txTimeout <= toutNext;
         periodSel <= periodNext;
      end
   end

   lbs_lane_drv #(
      .LANES(LANES)
   ) u_lane (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .burstOn(burstOn),
      .laneLfps(txLfps),
      .laneIdle(txElecIdle)
   );

   lbs_rx_class #(
      .CNT_W(12)
   ) u_rx (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rxLfps(rxLfps),
      .enhRate(enhRate),
      .evt(evt)
   );

   assign rxPing = evt.ping;
   assign rxPoll = evt.poll;
   assign rxU1Exit = evt.u1Exit;
   assign rxLongBurst = evt.longBurst;

   // gap length helper, counts idle cycles since the last burst
   logic [CNT_W-1:0] gapLenReg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gapLenReg <= '0;
      end else begin
         gapLenReg <= burstOn ? '0 : gapLenReg + 1'b1;
      end
   end

   sequence s_pollBurst;
      burstOn[*8] ##1 burstOn[*2] ##1 !burstOn;
   endsequence
   property p_pollLen;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(burstOn) && kindReg == lbs_pkg::K_POLL |-> s_pollBurst;
   endproperty
   a_pollLen: assert property (p_pollLen) else $error("poll length");

   property p_pollRep;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(burstOn) && $past(stateReg) == lbs_pkg::TX_GAP &&
      kindReg == lbs_pkg::K_POLL |-> $past(gapLenReg) == 89;
   endproperty
   a_pollRep: assert property (p_pollRep) else $error("poll repeat");

   property p_pingLen;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(burstOn) && kindReg == lbs_pkg::K_PING && !enhReg |=>
      burstOn ##1 !burstOn;
   endproperty
   a_pingLen: assert property (p_pingLen) else $error("ping length");

   property p_pingEnh;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(burstOn) && kindReg == lbs_pkg::K_PING && enhReg |=> !burstOn;
   endproperty
   a_pingEnh: assert property (p_pingEnh) else $error("ping too long");

   property p_u1Min;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(burstOn) && kindReg == lbs_pkg::K_U1 |-> burstOn[*8] ##1 burstOn;
   endproperty
   a_u1Min: assert property (p_u1Min) else $error("u1 exit short");

   property p_exitMin;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(burstOn) && isExit && kindReg != lbs_pkg::K_U1 |->
      $past(cntReg) >= 799;
   endproperty
   a_exitMin: assert property (p_exitMin) else $error("exit short");

   property p_warmLen;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(burstOn) && kindReg == lbs_pkg::K_WARM |->
      $past(cntReg) == WARM_CYC - 1 && txDone;
   endproperty
   a_warmLen: assert property (p_warmLen) else $error("warm length");

   property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      burstOn && isExit && !(stopReg || txStop) &&
      cntReg != exitMax - 1'b1 |=> burstOn;
   endproperty
   a_hold: assert property (p_hold) else $error("lfps dropped");

   property p_stopEnd;
      @(posedge ref_clk) disable iff (!rst_n)
      burstOn && isExit && (stopReg || txStop) &&
      cntReg >= exitMin - 1'b1 |=> !burstOn && txDone && !txTimeout;
   endproperty
   a_stopEnd: assert property (p_stopEnd) else $error("no stop");

   property p_noGap;
      @(posedge ref_clk) disable iff (!rst_n)
      burstOn && isRep && cntReg < burstLen - 1'b1 |=> burstOn;
   endproperty
   a_noGap: assert property (p_noGap) else $error("gap in burst");
endmodule : lbs_top

/* File: inc/lbs_cfg.svh */
// timing constants of the lfps burst block, as times and clock counts
// assumes the local clock period below; least times round up
`ifndef LBS_CFG_SVH
`define LBS_CFG_SVH

`define LBS_CLK_NS 100
`define LBS_UP(t) (((t) + `LBS_CLK_NS - 1) / `LBS_CLK_NS)
`define LBS_DN(t) ((t) / `LBS_CLK_NS)

// transmit burst and repeat times in ns
`define LBS_POLL_BURST_NS 1000
`define LBS_POLL_REP_NS 10000
`define LBS_PING_MAX_NS 200
`define LBS_PING_MAX_ENH_NS 160
`define LBS_PING_REP_NS 200000000
`define LBS_WARM_NS 100000000
`define LBS_U1_MIN_NS 900
`define LBS_EXIT_MIN_NS 80000
`define LBS_MAX2MS_NS 2000000
`define LBS_U3_MAX_NS 10000000
// receive thresholds in ns
`define LBS_U1_DET_NS 300
`define LBS_POLL_MIN_NS 600
`define LBS_POLL_MAX_NS 1400

// clock counts
`define LBS_POLL_BURST_CYC `LBS_DN(`LBS_POLL_BURST_NS)
`define LBS_POLL_REP_CYC `LBS_DN(`LBS_POLL_REP_NS)
`define LBS_PING_CYC `LBS_DN(`LBS_PING_MAX_NS)
`define LBS_PING_ENH_CYC `LBS_DN(`LBS_PING_MAX_ENH_NS)
`define LBS_PING_REP_CYC `LBS_DN(`LBS_PING_REP_NS)
`define LBS_WARM_CYC `LBS_DN(`LBS_WARM_NS)
`define LBS_U1_MIN_CYC `LBS_UP(`LBS_U1_MIN_NS)
`define LBS_EXIT_MIN_CYC `LBS_UP(`LBS_EXIT_MIN_NS)
`define LBS_MAX2MS_CYC `LBS_DN(`LBS_MAX2MS_NS)
`define LBS_U3_MAX_CYC `LBS_DN(`LBS_U3_MAX_NS)
`define LBS_U1_DET_CYC `LBS_UP(`LBS_U1_DET_NS)
`define LBS_RX_POLL_MIN_CYC `LBS_UP(`LBS_POLL_MIN_NS)
`define LBS_RX_POLL_MAX_CYC `LBS_DN(`LBS_POLL_MAX_NS)
`define LBS_RX_PING_CYC `LBS_DN(`LBS_PING_MAX_NS)
`define LBS_RX_PING_ENH_CYC `LBS_DN(`LBS_PING_MAX_ENH_NS)

`endif

/* File: inc/lbs_pkg.sv */
// types of the lfps burst block
// assumes nothing of its surroundings
package lbs_pkg;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_BURST = 2'b01,
      TX_GAP = 2'b10
   } lbs_tx_state_t;

   typedef enum logic [2:0] {
      K_POLL = 3'b000,
      K_PING = 3'b001,
      K_WARM = 3'b010,
      K_U1 = 3'b011,
      K_U2 = 3'b100,
      K_LPBK = 3'b101,
      K_U3 = 3'b110
   } lbs_kind_t;

endpackage : lbs_pkg

/* File: inc/lbs_evt_if.sv */
// receive events passed from the classifier to the top
// assumes all signals are in the local clock domain
interface lbs_evt_if;
   logic ping;
   logic poll;
   logic u1Exit;
   logic longBurst;
   modport src (output ping, output poll, output u1Exit, output longBurst);
   modport snk (input ping, input poll, input u1Exit, input longBurst);
endinterface : lbs_evt_if

/* File: rtl/lbs_rx_class.sv */
// lfps receive classifier: measures burst length, emits events
// assumes rxLfps is a clean synchronous squelch level
`include "lbs_cfg.svh"
module lbs_rx_class #(
   parameter int CNT_W = 10   // burst length counter width
) (
   input wire logic ref_clk,   // local clock
   input wire logic rst_n,     // async reset, active low
   input wire logic rxLfps,    // high while lfps is seen
   input wire logic enhRate,   // gen2 or two-lane operation
   lbs_evt_if.src evt          // one-cycle events
);
   localparam logic [CNT_W-1:0] U1_DET = CNT_W'(`LBS_U1_DET_CYC);
   localparam logic [CNT_W-1:0] LONG = CNT_W'(`LBS_EXIT_MIN_CYC);
   localparam logic [CNT_W-1:0] P_MIN = CNT_W'(`LBS_RX_POLL_MIN_CYC);
   localparam logic [CNT_W-1:0] P_MAX = CNT_W'(`LBS_RX_POLL_MAX_CYC);
   localparam logic [CNT_W-1:0] PG = CNT_W'(`LBS_RX_PING_CYC);
   localparam logic [CNT_W-1:0] PG_E = CNT_W'(`LBS_RX_PING_ENH_CYC);

   logic [CNT_W-1:0] lenReg, lenNext;
   logic pingNext, pollNext, u1Next, longNext;

   always_comb begin
      lenNext = lenReg;
      pingNext = 1'b0;
      pollNext = 1'b0;
      u1Next = 1'b0;
      longNext = 1'b0;
      if (rxLfps) begin
         if (lenReg != '1) begin
            lenNext = lenReg + 1'b1;
         end
         u1Next = (lenReg == U1_DET - 1'b1);
         longNext = (lenReg == LONG - 1'b1);
      end else begin
         lenNext = '0;
         // decided on this burst's length only
         pingNext = (lenReg != '0) &&
                    (lenReg <= (enhRate ? PG_E : PG));
         pollNext = (lenReg >= P_MIN) && (lenReg <= P_MAX);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lenReg <= '0;
         evt.ping <= 1'b0;
         evt.poll <= 1'b0;
         evt.u1Exit <= 1'b0;
         evt.longBurst <= 1'b0;
      end else begin
         lenReg <= lenNext;
         evt.ping <= pingNext;
         evt.poll <= pollNext;
         evt.u1Exit <= u1Next;
         evt.longBurst <= longNext;
      end
   end

   property p_rxU1;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(rxLfps) ##1 rxLfps[*2] |=> evt.u1Exit;
   endproperty
   a_rxU1: assert property (p_rxU1) else $error("u1 exit not seen");

   property p_rxPing;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(rxLfps) ##1 !rxLfps |=> evt.ping && !evt.u1Exit;
   endproperty
   a_rxPing: assert property (p_rxPing) else $error("ping missed");

   sequence s_rxPollBurst;
      $rose(rxLfps) ##1 rxLfps[*8] ##1 rxLfps ##1 !rxLfps;
   endsequence
   property p_rxPoll;
      @(posedge ref_clk) disable iff (!rst_n)
      s_rxPollBurst |=> evt.poll && !evt.ping;
   endproperty
   a_rxPoll: assert property (p_rxPoll) else $error("polling missed");
endmodule : lbs_rx_class

/* File: rtl/lbs_lane_drv.sv */
// per-lane lfps transmit enables and electrical idle flags
// assumes lane 0 is the configuration lane
module lbs_lane_drv #(
   parameter int LANES = 2   // number of lanes, at least two
) (
   input wire logic ref_clk,             // local clock
   input wire logic rst_n,               // async reset, active low
   input wire logic burstOn,             // burst in progress
   output logic [LANES-1:0] laneLfps,    // lfps oscillator enable
   output logic [LANES-1:0] laneIdle     // electrical idle per lane
);
   logic [LANES-1:0] lfpsNext;

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      if (i == 0) begin : g_cfg
         assign lfpsNext[i] = burstOn;
      end else begin : g_other
         assign lfpsNext[i] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         laneLfps <= '0;
      end else begin
         laneLfps <= lfpsNext;
      end
   end

   assign laneIdle = ~laneLfps;

   property p_cfgLane;
      @(posedge ref_clk) disable iff (!rst_n)
      burstOn |=> laneLfps[0] && !(|laneLfps[LANES-1:1]);
   endproperty
   a_cfgLane: assert property (p_cfgLane) else $error("lane use wrong");

   property p_idle;
      @(posedge ref_clk) disable iff (!rst_n)
      !burstOn |=> laneIdle[0] && !laneLfps[0];
   endproperty
   a_idle: assert property (p_idle) else $error("not idle in gap");
endmodule : lbs_lane_drv

/* File: dv/lbs_peer.sv */
// link partner model: sends lfps bursts of chosen length to the port
// assumes rxLfps is a clean squelch level, low between bursts
module lbs_peer (
   input wire logic ref_clk,   // local clock
   input wire logic lineIn,    // lfps from the configuration lane
   output logic rxLfps         // lfps level seen by the port
);
   timeunit 1ns;
   timeprecision 1ns;
   int txBursts = 0;
   logic lineLast = 1'b0;
   initial rxLfps = 1'b0;
   // counts bursts arriving from the port
   always @(negedge ref_clk) begin
      if (lineIn === 1'b1 && lineLast !== 1'b1) txBursts++;
      lineLast = lineIn;
   end
   // burst length alone tells the message kind
   task automatic send(input int n);
      @(posedge ref_clk);
      #1;
      rxLfps = 1'b1;
      repeat (n) @(posedge ref_clk);
      #1;
      rxLfps = 1'b0;
   endtask : send
endmodule : lbs_peer

/* File: dv/lbs_top_tb.sv */
// self-checking bench of the lfps burst generator and classifier
// assumes the package, event interface and config header are compiled
module lbs_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PING_REP = 300;
   localparam int WARM = 200;
   localparam int MAX2MS = 1000;
   localparam int U3MAX = 1500;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reqValid = 1'b0;
   lbs_pkg::lbs_kind_t reqKind = lbs_pkg::K_POLL;
   logic txStop = 1'b0;
   logic enhRate = 1'b0;
   logic rxLfps;
   logic reqReady, periodSel, txDone, txTimeout;
   logic rxPing, rxPoll, rxU1Exit, rxLongBurst;
   logic [1:0] txLfps, txElecIdle;
   int fails = 0;
   int checkCount = 0;
   int doneCnt = 0, toutCnt = 0, laneErr = 0;
   int pingCnt = 0, pollCnt = 0, u1Cnt = 0, longCnt = 0;

   always #50 ref_clk = ~ref_clk;

   lbs_top #(.LANES(2), .CNT_W(21), .PING_REP_CYC(PING_REP),
      .WARM_CYC(WARM), .MAX2MS_CYC(MAX2MS), .U3_MAX_CYC(U3MAX)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid),
      .reqKind(reqKind), .reqReady(reqReady), .txStop(txStop),
      .enhRate(enhRate), .rxLfps(rxLfps), .txLfps(txLfps),
      .txElecIdle(txElecIdle), .periodSel(periodSel), .txDone(txDone),
      .txTimeout(txTimeout), .rxPing(rxPing), .rxPoll(rxPoll),
      .rxU1Exit(rxU1Exit), .rxLongBurst(rxLongBurst));

   lbs_peer i_peer (.ref_clk(ref_clk), .lineIn(txLfps[0]),
      .rxLfps(rxLfps));

   // high cycles of each pulse output; a one-cycle pulse counts once
   always @(negedge ref_clk) begin
      doneCnt += int'(txDone === 1'b1);
      toutCnt += int'(txTimeout === 1'b1);
      pingCnt += int'(rxPing === 1'b1);
      pollCnt += int'(rxPoll === 1'b1);
      u1Cnt += int'(rxU1Exit === 1'b1);
      longCnt += int'(rxLongBurst === 1'b1);
      if (rst_n === 1'b1 && (txLfps[1] !== 1'b0 ||
         (txLfps[0] !== 1'b0 && txLfps[0] !== 1'b1) ||
         txElecIdle !== ~txLfps)) laneErr++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic req(input lbs_pkg::lbs_kind_t k);
      check(reqReady, 1'b1);
      reqKind = k;
      reqValid = 1'b1;
      tick(1);
      reqValid = 1'b0;
   endtask : req

   task automatic waitRise(input int lim, output int w);
      w = 0;
      while (txLfps[0] !== 1'b1 && w < lim) begin
         tick(1);
         w++;
      end
   endtask : waitRise

   task automatic burstLen(output int len);
      len = 0;
      while (txLfps[0] === 1'b1 && len < 3000) begin
         tick(1);
         len++;
      end
   endtask : burstLen

   // stop in the gap, then no further burst may follow
   task automatic stopGap();
      int d0, b0;
      d0 = doneCnt;
      txStop = 1'b1;
      tick(2);
      txStop = 1'b0;
      tick(2);
      check(doneCnt - d0, 1);
      b0 = i_peer.txBursts;
      tick(PING_REP + 50);
      check(i_peer.txBursts - b0, 0);
   endtask : stopGap

   task automatic t_repeat(input lbs_pkg::lbs_kind_t k, input logic enh,
      input int blen, input int rep);
      int w, len;
      enhRate = enh;
      req(k);
      waitRise(5, w);
      check(w, 1);
      check(periodSel, enh);
      burstLen(len);
      check(len, blen);
      waitRise(rep + 10, w);
      check(w + len, rep);
      burstLen(len);
      check(len, blen);
      stopGap();
   endtask : t_repeat

   task automatic t_warm();
      int w, len, d0, b0;
      d0 = doneCnt;
      txStop = 1'b1;
      req(lbs_pkg::K_WARM);
      waitRise(5, w);
      burstLen(len);
      check(len, WARM);
      tick(2);
      check(doneCnt - d0, 1);
      txStop = 1'b0;
      b0 = i_peer.txBursts;
      tick(2 * WARM);
      check(i_peer.txBursts - b0, 0);
   endtask : t_warm

   task automatic t_exit(input lbs_pkg::lbs_kind_t k, input logic stop,
      input int blen, input int tout);
      int w, len, d0, t0;
      d0 = doneCnt;
      t0 = toutCnt;
      txStop = stop;
      req(k);
      waitRise(5, w);
      burstLen(len);
      txStop = 1'b0;
      tick(3);
      check(len, blen);
      check(toutCnt - t0, tout);
      check(doneCnt - d0, 1 - tout);
   endtask : t_exit

   task automatic t_rx(input int n, input logic enh, input int ePing,
      input int ePoll, input int eU1, input int eLong);
      int p0, q0, u0, l0;
      p0 = pingCnt;
      q0 = pollCnt;
      u0 = u1Cnt;
      l0 = longCnt;
      enhRate = enh;
      i_peer.send(n);
      tick(4);
      check(pingCnt - p0, ePing);
      check(pollCnt - q0, ePoll);
      check(u1Cnt - u0, eU1);
      check(longCnt - l0, eLong);
   endtask : t_rx

   initial begin
      #(20000 * 100);
      fails++;
      summarize();
   end

   initial begin
      tick(11);
      check(reqReady, 1'b1);
      check(txElecIdle, 2'b11);
      check(txLfps, 2'b00);
      tick(1);
      rst_n = 1'b1;
      tick(1);
      t_repeat(lbs_pkg::K_POLL, 1'b0, 10, 100);
      t_repeat(lbs_pkg::K_PING, 1'b0, 2, PING_REP);
      t_repeat(lbs_pkg::K_PING, 1'b1, 1, PING_REP);
      enhRate = 1'b0;
      t_warm();
      t_exit(lbs_pkg::K_U1, 1'b1, 9, 0);
      t_exit(lbs_pkg::K_U2, 1'b1, 800, 0);
      t_exit(lbs_pkg::K_LPBK, 1'b0, MAX2MS, 1);
      t_exit(lbs_pkg::K_U2, 1'b0, MAX2MS, 1);
      t_exit(lbs_pkg::K_U3, 1'b0, U3MAX, 1);
      t_rx(1, 1'b0, 1, 0, 0, 0);
      t_rx(2, 1'b0, 1, 0, 0, 0);
      t_rx(2, 1'b1, 0, 0, 0, 0);
      t_rx(1, 1'b1, 1, 0, 0, 0);
      t_rx(3, 1'b0, 0, 0, 1, 0);
      t_rx(5, 1'b0, 0, 0, 1, 0);
      t_rx(6, 1'b0, 0, 1, 1, 0);
      t_rx(10, 1'b0, 0, 1, 1, 0);
      t_rx(14, 1'b0, 0, 1, 1, 0);
      t_rx(15, 1'b0, 0, 0, 1, 0);
      t_rx(800, 1'b0, 0, 0, 1, 1);
      check(laneErr, 0);
      summarize();
   end
endmodule : lbs_top_tb
